// ---- rtl/pfta_pkg.sv ----
// Constants shared by both ends of the flash table access link.
// Assumes a single core clock at 250 MHz on both ends.
package pfta_pkg;
  // Link register indices seen by the core
  localparam logic [3:0] IDX_CTRL   = 4'h0; // memory_control_reg
  localparam logic [3:0] IDX_UNLOCK = 4'h1; // unlock_sequence_port
  localparam logic [3:0] IDX_LATCH  = 4'h2; // table_byte_latch
  localparam logic [3:0] IDX_PTR_LO = 4'h3; // table_pointer_low
  localparam logic [3:0] IDX_PTR_HI = 4'h4; // table_pointer high byte
  localparam logic [3:0] IDX_NVDATA = 4'h5; // nv_data_reg
  localparam logic [3:0] IDX_NVADDR = 4'h6; // nv_address_reg
  localparam logic [3:0] IDX_FLAGS  = 4'h7; // peripheral_flag_reg_two
  localparam logic [3:0] IDX_TRD    = 4'h8; // table_read_op strobe
  localparam logic [3:0] IDX_TWR    = 4'h9; // table_write_op strobe
  // memory_control_reg and peripheral_flag_reg_two bit positions
  localparam int CTL_CODE   = 7; // code_space_select
  localparam int CTL_CFG    = 6; // config_space_select
  localparam int CTL_ERASE  = 4; // row erase select
  localparam int CTL_ABORT  = 3; // program_abort_flag
  localparam int CTL_UNLOCK = 2; // program_unlock_bit
  localparam int CTL_WR     = 1; // program start
  localparam int CTL_RD     = 0; // read start
  localparam int FLG_DONE   = 4; // completion_irq_flag
  // Array geometry
  localparam int WRITE_BLOCK = 8;  // Bytes per program write
  localparam int ERASE_ROW   = 64; // Bytes per row erase
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  // Self-timer length
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_TIME_NS = 1000;
  localparam int WRITE_CYC =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Operator APB map
  localparam logic [11:0] APB_OP   = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam int OP_WE    = 8;  // Write rather than read
  localparam int OP_RELK  = 9;  // Relock after a control write with unlock set
  localparam int OP_DATA  = 16; // Data byte lsb
  localparam int ST_PEND  = 8;
  localparam int ST_STALL = 9;
  localparam int ST_IRQ   = 10;
endpackage

// ---- rtl/pfta_link_if.sv ----
// Link between the core-side operator and the flash sequencer.
// Both ends run on pclk; no clocking block.
interface pfta_link_if;
  logic       req;         // Request held until ack
  logic       we;          // Write when high
  logic [3:0] addr;        // Register index
  logic [7:0] wdata;       // Write byte
  logic       ack;         // One-cycle answer
  logic [7:0] rdata;       // Read byte, valid with ack
  logic       fetch_stall; // Instruction fetch halted
  logic       irq_flag;    // completion_irq_flag level
  modport device   (input req, we, addr, wdata,
                    output ack, rdata, fetch_stall, irq_flag);
  modport operator (output req, we, addr, wdata,
                    input ack, rdata, fetch_stall, irq_flag);
endinterface

// ---- rtl/pfta_device.sv ----
// Flash sequencer: program memory, data EEPROM, config bytes,
// table latch and pointer, self-timed write and row erase.
// Assumes the operator holds req steady until ack.
// Operation
// - Table read returns one byte only
// - Program write commits 8-byte holding block
// - Erase works on 64-byte rows
// - No bulk erase from core
// - Busy stalls fetch and all access
// - Self-timer ends write and erase
// - Any value accepted into program memory
// - Bytes pass only through table latch
// - Read loads latch; write fills holding
// - Any byte address allowed; code word-aligned
// - Unlock port stores nothing, reads zero
// - Code select picks EEPROM or program
// - Config select overrides code select (read start is still refused while code select is set)
// - Erase select turns start into erase in code space
// - Start ignored while unlock clear
// - Clearing unlock never stops operation
// - Operator keeps unlock clear normally
// - Reset during write sets abort flag
// - Reset clears nv data and address
// - Start bits self-clear on completion
// - Read start refused in code space
// - Done sets flag; only writes clear
// - Erase ignores pointer[5:0], clears erase select
//
// Implementation choices: the APB register port and the register offsets.
module pfta_device
  import pfta_pkg::*;
#(
  parameter int PM_BYTES  = 1024,     // Program memory size
  parameter int EE_BYTES  = 256,      // Data EEPROM size
  parameter int CFG_BYTES = 16,       // Configuration bytes
  parameter int WR_CYCLES = WRITE_CYC // Self-timer length
)(
  input wire logic      pclk,
  input wire logic      presetn,  // System reset
  input wire logic      por_n,    // Power-on reset only
  pfta_link_if.device   lnk
);
  localparam int PW = $clog2(PM_BYTES);
  localparam int EW = $clog2(EE_BYTES);
  localparam int CW = $clog2(CFG_BYTES);
  localparam int TW = $clog2(WR_CYCLES + 1);

  logic [15:0]   pm_q   [PM_BYTES/2];  // 16-bit program words
  logic [7:0]    ee_q   [EE_BYTES];    // Data EEPROM
  logic [7:0]    cfg_q  [CFG_BYTES];   // Configuration bytes
  logic [7:0]    hold_q [WRITE_BLOCK]; // Holding registers
  logic          ack_q;
  logic [7:0]    rdata_q;
  logic [7:0]    latch_q;              // table_byte_latch
  logic [15:0]   ptr_q;                // table_pointer
  logic [7:0]    nvdata_q;
  logic [7:0]    nvaddr_q;
  logic          unlock_q, erase_q, busy_q, flag_q;
  logic [TW-1:0] cnt_q;                // Self-timer countdown
  logic          code_q, cfgsel_q;     // Survive system reset
  logic          pend_q, abort_q;      // Write pending, abort

  // Access is taken once per request and never while busy
  wire          take    = lnk.req & ~ack_q & ~busy_q;
  wire          wr_en   = take & lnk.we;
  wire          rd_en   = take & ~lnk.we;
  wire [7:0]    w       = lnk.wdata;
  wire          wr_ctrl = wr_en & (lnk.addr == IDX_CTRL);
  wire          wr_flag = wr_en & (lnk.addr == IDX_FLAGS);
  wire          start   = wr_ctrl & w[CTL_WR] & unlock_q;
  wire          rd_nv   = wr_ctrl & w[CTL_RD] & ~code_q;
  wire          tbl_rd  = take & (lnk.addr == IDX_TRD);
  wire          tbl_wr  = take & (lnk.addr == IDX_TWR);
  wire          done    = busy_q & (cnt_q == '0);
  wire [PW-1:0] pbyte   = ptr_q[PW-1:0];
  wire [PW-7:0] row     = pbyte[PW-1:6];
  wire [PW-4:0] blk     = pbyte[PW-1:3];
  wire [15:0]   pword   = pm_q[pbyte[PW-1:1]];
  wire [7:0]    pm_byte = pbyte[0] ? pword[15:8] : pword[7:0];
  wire [7:0]    tbl_byte = cfgsel_q ? cfg_q[pbyte[CW-1:0]]
                                    : pm_byte;
  wire [7:0]    nv_byte = cfgsel_q ? cfg_q[nvaddr_q[CW-1:0]]
                                   : ee_q[nvaddr_q[EW-1:0]];
  wire [7:0]    ctrl_rd = {code_q, cfgsel_q, 1'b0, erase_q,
                           abort_q, unlock_q, busy_q, 1'b0};

  // Read mux; the unlock port and strobes have no storage
  logic [7:0] rd_mux;
  always_comb begin
    case (lnk.addr)
      IDX_CTRL:   rd_mux = ctrl_rd;
      IDX_LATCH:  rd_mux = latch_q;
      IDX_PTR_LO: rd_mux = ptr_q[7:0];
      IDX_PTR_HI: rd_mux = ptr_q[15:8];
      IDX_NVDATA: rd_mux = nvdata_q;
      IDX_NVADDR: rd_mux = nvaddr_q;
      IDX_FLAGS:  rd_mux = 8'(flag_q) << FLG_DONE;
      default:    rd_mux = 8'h00;
    endcase
  end

  // Link answer, one cycle after the request is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= take;
      if (rd_en) rdata_q <= rd_mux;
    end
  end

  // Pointer, latch and nv registers; reset wipes nv regs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q    <= 16'h0000;
      latch_q  <= 8'h00;
      nvdata_q <= 8'h00;
      nvaddr_q <= 8'h00;
    end else begin
      if (wr_en && lnk.addr == IDX_PTR_LO) ptr_q[7:0] <= w;
      if (wr_en && lnk.addr == IDX_PTR_HI) ptr_q[15:8] <= w;
      // Core writes the latch directly; array bytes only via it
      if (wr_en && lnk.addr == IDX_LATCH) latch_q <= w;
      else if (tbl_rd) latch_q <= tbl_byte;
      if (wr_en && lnk.addr == IDX_NVADDR) nvaddr_q <= w;
      if (rd_nv) nvdata_q <= nv_byte;
      else if (wr_en && lnk.addr == IDX_NVDATA) nvdata_q <= w;
    end
  end

  // Control bits, self-timer and completion flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 1'b0;
      erase_q  <= 1'b0;
      busy_q   <= 1'b0;
      cnt_q    <= '0;
      flag_q   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        unlock_q <= w[CTL_UNLOCK];
        erase_q  <= w[CTL_ERASE];
      end else if (done && erase_q && code_q && !cfgsel_q) begin
        erase_q <= 1'b0;
      end
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= TW'(WR_CYCLES - 1);
      end else if (done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
      // A completion in the clearing cycle still sets the flag
      flag_q <= done | (flag_q & ~(wr_flag & ~w[FLG_DONE]));
    end
  end

  // Bits that outlive system reset, bar pend_q; reset mid-write is caught
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      code_q   <= 1'b0;
      cfgsel_q <= 1'b0;
      pend_q   <= 1'b0;
      abort_q  <= 1'b0;
    end else if (!presetn) begin
      pend_q <= 1'b0;
      if (pend_q) abort_q <= 1'b1;
    end else begin
      if (wr_ctrl) begin
        code_q   <= w[CTL_CODE];
        cfgsel_q <= w[CTL_CFG];
        abort_q  <= w[CTL_ABORT];
      end
      if (start) pend_q <= 1'b1;
      else if (done) pend_q <= 1'b0;
    end
  end

  // Array updates; no bulk erase path exists at all
  always_ff @(posedge pclk) begin
    if (tbl_wr) hold_q[pbyte[2:0]] <= latch_q;
    if (done) begin
      if (cfgsel_q) begin
        cfg_q[nvaddr_q[CW-1:0]] <= nvdata_q;
      end else if (!code_q) begin
        ee_q[nvaddr_q[EW-1:0]] <= nvdata_q;
      end else if (erase_q) begin
        for (int i = 0; i < ERASE_ROW / 2; i++) begin
          pm_q[{row, 5'(i)}] <= ERASED_WORD;
        end
      end else begin
        // Raw bytes stored as is; the core treats bad opcodes as no-op
        for (int i = 0; i < WRITE_BLOCK / 2; i++) begin
          pm_q[{blk, 2'(i)}] <= {hold_q[2*i+1], hold_q[2*i]};
        end
      end
    end
  end

  // Link outputs straight from flip-flops
  assign lnk.ack         = ack_q;
  assign lnk.rdata       = rdata_q;
  assign lnk.fetch_stall = busy_q;
  assign lnk.irq_flag    = flag_q;
endmodule

// ---- rtl/pfta_operator.sv ----
// Core-side operator: takes link orders from APB and runs them.
// Assumes software builds the unlock and start sequences itself.
module pfta_operator
  import pfta_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic     [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  pfta_link_if.operator   lnk
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00, // No link request
    ST_REQ   = 2'b01, // Ordered access in flight
    ST_RELCK = 2'b10  // Follow-up write clearing unlock
  } pfta_op_st_t;

  pfta_op_st_t st_q;
  logic        req_q, we_q, relk_q;
  logic [3:0]  addr_q;
  logic [7:0]  wdata_q, last_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;

  // APB decode; an order waits while the link is busy
  wire access  = psel & penable & ~pready_q;
  wire hit_op  = paddr == APB_OP;
  wire hit_st  = paddr == APB_STAT;
  wire op_wr   = access & pwrite & hit_op;
  wire accept  = access & (~op_wr | (st_q == ST_IDLE));
  wire launch  = accept & op_wr;
  wire relock  = relk_q & we_q & (addr_q == IDX_CTRL)
               & wdata_q[CTL_UNLOCK];
  wire [31:0] stat = {21'h0, lnk.irq_flag, lnk.fetch_stall,
                      st_q != ST_IDLE, last_q};
  wire [31:0] op_rd = {8'h0, wdata_q, 6'h0, relk_q, we_q,
                       4'h0, addr_q};

  // APB answer registered: ready one cycle into access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= accept;
      pslverr_q <= accept & ~hit_op & ~hit_st;
      if (accept && !pwrite) begin
        prdata_q <= hit_st ? stat : (hit_op ? op_rd : 32'h0);
      end
    end
  end

  // Link sequencer; start bits, flag clears pass from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      relk_q  <= 1'b0;
      addr_q  <= 4'h0;
      wdata_q <= 8'h00;
      last_q  <= 8'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (launch) begin
            req_q   <= 1'b1;
            we_q    <= pwdata[OP_WE];
            relk_q  <= pwdata[OP_RELK];
            addr_q  <= pwdata[3:0];
            wdata_q <= pwdata[OP_DATA +: 8];
            st_q    <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (lnk.ack) begin
            last_q <= lnk.rdata;
            if (relock) begin
              // Drop unlock and start bits; the write keeps running
              wdata_q <= wdata_q & ~8'h07;
              st_q    <= ST_RELCK;
            end else begin
              req_q <= 1'b0;
              st_q  <= ST_IDLE;
            end
          end
        end
        ST_RELCK: begin
          if (lnk.ack) begin
            req_q <= 1'b0;
            st_q  <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign lnk.req   = req_q;
  assign lnk.we    = we_q;
  assign lnk.addr  = addr_q;
  assign lnk.wdata = wdata_q;
endmodule

// ---- tb/pfta_link_sva.sv ----
// Checker on the link between the operator and the sequencer.
// Assumes it sits beside the one interface that joins both ends.
module pfta_link_sva
  import pfta_pkg::*;
#(
  parameter int WR_CYCLES = WRITE_CYC // Self-timer length
)(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       req,
  input wire logic       we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       fetch_stall,
  input wire logic       irq_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] stall_cnt_q; // Busy cycles seen in this operation
  // Restart on idle so that one overlong run cannot hide behind another
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stall_cnt_q <= 16'h0000;
    else
      stall_cnt_q <= fetch_stall ? stall_cnt_q + 16'h0001 : 16'h0000;
  end
  property p_stall_blocks;
    fetch_stall && $past(fetch_stall) |-> !ack;
  endproperty
  a_stall_blocks: assert property (p_stall_blocks)
    else $error("link answered while busy");
  property p_timer_len;
    $fell(fetch_stall) |-> stall_cnt_q == WR_CYCLES;
  endproperty
  a_timer_len: assert property (p_timer_len)
    else $error("busy span has the wrong length");
  property p_timer_bound;
    stall_cnt_q <= WR_CYCLES;
  endproperty
  a_timer_bound: assert property (p_timer_bound)
    else $error("busy span runs past the timer");
  property p_start_gate;
    $rose(fetch_stall) |->
      ack && $past(req && we && addr == IDX_CTRL && wdata[CTL_WR]);
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("busy began without a start write");
  property p_done_flag;
    $rose(irq_flag) |-> $fell(fetch_stall);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("completion flag rose outside completion");
  property p_flag_clear;
    $fell(irq_flag) |->
      $past(req && we && addr == IDX_FLAGS && !wdata[FLG_DONE]);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("completion flag fell with no clearing write");
  property p_unlock_zero;
    ack && $past(req && !we && addr == IDX_UNLOCK) |-> rdata == 8'h00;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("unlock port read back nonzero");
  property p_ctl_starts;
    ack && $past(req && !we && addr == IDX_CTRL) |-> rdata[1:0] == 2'b00;
  endproperty
  a_ctl_starts: assert property (p_ctl_starts)
    else $error("start bits read set while idle");
  // Main scenarios
  c_done: cover property ($rose(irq_flag));
  c_clear: cover property ($fell(irq_flag));
  c_busy: cover property ($rose(fetch_stall));
endmodule

// ---- tb/tb_program_flash_table_access.sv ----
// Testbench: both ends joined by the link, driven over APB.
// Assumes the self-timer is cut to 8 cycles to keep the run short.
module tb_program_flash_table_access
  import pfta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WRC = 8;        // Short self-timer
  logic        pclk, presetn, por_n;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r; // r holds the read word of the last APB transfer
  logic        err;               // Error answer of the last transfer
  int          n_fail, n_compared;
  pfta_link_if lnk ();
  pfta_device #(.WR_CYCLES(WRC)) pfta_device_inst (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .lnk(lnk));
  pfta_operator pfta_operator_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  pfta_link_sva #(.WR_CYCLES(WRC)) pfta_link_sva_inst (
    .pclk(pclk), .presetn(presetn), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .rdata(lnk.rdata), .fetch_stall(lnk.fetch_stall),
    .irq_flag(lnk.irq_flag));
  // Free-running core clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; an idle edge follows so calls never collide
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Issue a link order, then poll status until it is no longer pending
  task automatic lop(input logic [3:0] i, input logic w,
                     input logic [7:0] d, input logic rl);
    int n;
    apb(1'b1, APB_OP, {8'h00, d, 6'h00, rl, w, 4'h0, i}, r);
    for (n = 0; n < 100; n++) begin
      apb(1'b0, APB_STAT, 32'h0, r);
      if (r[ST_PEND] === 1'b0)
        break;
    end
    if (n == 100)
      n_fail++;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    lop(i, 1'b1, d, 1'b0);
  endtask
  task automatic rdc(input string nm, input logic [3:0] i,
                     input logic [7:0] e);
    lop(i, 1'b0, 8'h00, 1'b0);
    chk(nm, e, r[7:0]);
  endtask
  // Cuts a hang short
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    por_n = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    wr(IDX_UNLOCK, 8'hff);
    rdc("unlock", IDX_UNLOCK, 8'h00);
    // Unmapped operator address answers with an error and zero data
    apb(1'b0, 12'h008, 32'h0, r);
    chk("slverr", 8'h01, {7'h0, err});
    chk("unmapped", 8'h00, r[7:0]);
    wr(IDX_CTRL, 8'h02);
    rdc("ctl_nostart", IDX_CTRL, 8'h00);
    chk("stall_nostart", 8'h00, {7'h0, r[ST_STALL]});
    // Fill holding block at 0x08 byte by byte through the latch
    wr(IDX_CTRL, 8'h80);
    for (int i = 0; i < WRITE_BLOCK; i++) begin
      wr(IDX_PTR_LO, 8'h08 + 8'(i));
      wr(IDX_LATCH, 8'ha0 + 8'(i));
      wr(IDX_TWR, 8'h00);
    end
    wr(IDX_CTRL, 8'h84);
    lop(IDX_CTRL, 1'b1, 8'h86, 1'b1);
    chk("irq_pm", 8'h01, {7'h0, r[ST_IRQ]});
    for (int i = 0; i < WRITE_BLOCK; i++) begin
      wr(IDX_PTR_LO, 8'h08 + 8'(i));
      wr(IDX_TRD, 8'h00);
      rdc("pm_byte", IDX_LATCH, 8'ha0 + 8'(i));
    end
    wr(IDX_FLAGS, 8'h00);
    chk("irq_clr", 8'h00, {7'h0, r[ST_IRQ]});
    // Row erase with the ignored pointer bits all set
    wr(IDX_PTR_LO, 8'h3f);
    wr(IDX_CTRL, 8'h94);
    // No relock here: a relock write would set the erase select again
    lop(IDX_CTRL, 1'b1, 8'h96, 1'b0);
    rdc("ctl_erase", IDX_CTRL, 8'h84);
    wr(IDX_CTRL, 8'h80);
    wr(IDX_PTR_LO, 8'h0b);
    wr(IDX_TRD, 8'h00);
    rdc("erased", IDX_LATCH, 8'hff);
    // Data EEPROM write, then read start
    wr(IDX_CTRL, 8'h00);
    wr(IDX_NVADDR, 8'h05);
    wr(IDX_NVDATA, 8'h5a);
    wr(IDX_CTRL, 8'h04);
    lop(IDX_CTRL, 1'b1, 8'h06, 1'b1);
    wr(IDX_NVDATA, 8'h00);
    wr(IDX_CTRL, 8'h01);
    rdc("ee_read", IDX_NVDATA, 8'h5a);
    wr(IDX_CTRL, 8'h80);
    wr(IDX_NVDATA, 8'h00);
    wr(IDX_CTRL, 8'h81);
    rdc("rd_code", IDX_NVDATA, 8'h00);
    // Config space overrides the code select
    wr(IDX_CTRL, 8'hc0);
    wr(IDX_NVDATA, 8'h3c);
    wr(IDX_CTRL, 8'hc4);
    lop(IDX_CTRL, 1'b1, 8'hc6, 1'b1);
    wr(IDX_CTRL, 8'h40);
    wr(IDX_NVDATA, 8'h00);
    wr(IDX_CTRL, 8'h41);
    rdc("cfg_read", IDX_NVDATA, 8'h3c);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h01);
    rdc("ee_kept", IDX_NVDATA, 8'h5a);
    // Reset in mid-write
    wr(IDX_CTRL, 8'h04);
    apb(1'b1, APB_OP, {16'h0006, 8'h01, 8'h00}, r);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("abort", IDX_CTRL, 8'h08);
    rdc("nv_data_rst", IDX_NVDATA, 8'h00);
    rdc("nv_addr_rst", IDX_NVADDR, 8'h00);
    // Retry the aborted write with both nv registers reloaded
    wr(IDX_NVADDR, 8'h05);
    wr(IDX_NVDATA, 8'h77);
    wr(IDX_CTRL, 8'h04);
    lop(IDX_CTRL, 1'b1, 8'h06, 1'b1);
    wr(IDX_NVDATA, 8'h00);
    wr(IDX_CTRL, 8'h01);
    rdc("ee_retry", IDX_NVDATA, 8'h77);
    give_verdict();
  end
endmodule
